// ---- verilog/rxc_pkg.sv ----
package rxc_pkg;
   // Register bus geometry
   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;
   localparam int SAMP_W = 12;

   // Register offsets
   localparam logic [8:0] OFS_MIX_DIV    = 9'h166;
   localparam logic [8:0] OFS_PWR_BYP    = 9'h167;
   localparam logic [8:0] OFS_ALIGN_OFF  = 9'h168;
   localparam logic [8:0] OFS_ALIGN_SRC  = 9'h169;
   localparam logic [8:0] OFS_ALIGN_STRB = 9'h16a;
   localparam logic [8:0] OFS_STATUS     = 9'h180;

   // Reset values
   localparam logic [7:0] RST_CFG = 8'h00;

   // rx_mixer_divider_ctrl fields
   localparam int B_MIX_EN     = 0;
   localparam int B_MIX_SEL    = 1;
   localparam int B_MIX_STEP   = 3;
   localparam int B_MIX_PRESET = 4;
   localparam int B_DIV_PRESET = 6;
   localparam int B_DIV_FLIP   = 7;

   // rx_power_bypass_ctrl fields
   localparam int B_CHAIN_OFF = 0;
   localparam int B_A_APPLY   = 1;
   localparam int B_A_PD      = 2;
   localparam int B_B_PD      = 3;
   localparam int B_B_APPLY   = 4;
   localparam int B_BYP       = 5;
   localparam int B_BYP_APPLY = 6;

   // Per-block bit order shared by disable, source and strobe registers
   localparam int B_MIX    = 0;
   localparam int B_DIV    = 1;
   localparam int B_IQOFS  = 2;
   localparam int B_IQGP   = 3;
   localparam int B_GLOBAL = 4;

   // Status register fields
   localparam int B_ST_PHASE = 0;
   localparam int B_ST_DIV   = 2;
   localparam int B_ST_PDA   = 3;
   localparam int B_ST_PDB   = 4;
   localparam int B_ST_OFF   = 5;

   // Output code of a powered-down channel (two's complement mid-scale)
   localparam logic [11:0] MID_CODE = 12'h000;

   // Default FIFO depth in samples
   localparam int FIFO_DEPTH = 32;

   // Coarse mixer modes
   typedef enum logic [1:0] {
      RXC_MIX_PASS = 2'h0,
      RXC_MIX_HALF = 2'h1,
      RXC_MIX_QPOS = 2'h2,
      RXC_MIX_QNEG = 2'h3
   } rxc_mix_mode_t;

   // One dual-channel sample, channel A as I and channel B as Q
   typedef struct packed {
      logic [SAMP_W-1:0] a;
      logic [SAMP_W-1:0] b;
   } rxc_sample_t;
endpackage

// ---- verilog/rxc_chain.sv ----
`timescale 1ns/10ps
// Contract
// - Mixer runs only while its enable is set.
// - Mode picks pass, Fs/2, +Fs/4 or -Fs/4.
// - Step bit rising advances mixer phase once, unsynced only.
// - Mixer sync loads the mixer phase preset.
// - Divider sync loads the divider phase preset.
// - Divider is used when decimation is enabled, except under bypass.
// - Flip bit rising inverts divider phase, unsynced only.
// - Chain off powers down all, outputs mid-code.
// - Channel down needs power-down and apply bits.
// - Without features or mixer, all four bits needed together.
// - Bypass plus apply routes inputs straight out.
// - Block sync disables act only under global disable.
// - Global sync on selected source rising edge.
// - Block source picks pin or block strobe.
// - Global source picks pin or global strobe.
// - Strobe bits zero to four, rising edge.

// Sample FIFO with a registered output stage
module rxc_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Fill side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             in_ready,
   // Drain side
   output      logic             out_valid,
   output      logic [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0]    wptr;
      logic [AW-1:0]    rptr;
      logic [AW:0]      count;
      logic             in_rdy;
      logic             out_v;
      logic [WIDTH-1:0] out_d;
   } rxc_fifo_st_t;

   rxc_fifo_st_t     st_reg;
   rxc_fifo_st_t     st_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push;
   logic             pop;

   // Ready is registered from the next count, so it never lies
   always_comb begin
      st_next = st_reg;
      push    = in_valid && st_reg.in_rdy;
      pop     = (st_reg.count != '0) && (!st_reg.out_v || out_ready);
      if (push) begin
         st_next.wptr = st_reg.wptr + 1'b1;
      end
      if (pop) begin
         st_next.rptr  = st_reg.rptr + 1'b1;
         st_next.out_v = 1'b1;
         st_next.out_d = mem[st_reg.rptr];
      end else if (out_ready) begin
         st_next.out_v = 1'b0;
      end
      st_next.count  = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
      st_next.in_rdy = st_next.count < (AW+1)'(DEPTH);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg        <= '0;
         st_reg.in_rdy <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // Storage has no reset; pointers guard stale words
   always_ff @(posedge clk) begin
      if (push) begin
         mem[st_reg.wptr] <= in_data;
      end
   end

   assign in_ready  = st_reg.in_rdy;
   assign out_valid = st_reg.out_v;
   assign out_data  = st_reg.out_d;
endmodule // rxc_fifo

// Receive chain mixer, divider, power and alignment control
module rxc_chain
   import rxc_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic              SYS_CLK,
   input  wire logic              RST,
   // Register port
   input  wire logic [ADDR_W-1:0] REG_ADDR,
   input  wire logic [DATA_W-1:0] REG_WDATA,
   input  wire logic              REG_WR,
   input  wire logic              REG_RD,
   output      logic [DATA_W-1:0] REG_RDATA,
   // Alignment pin and neighbouring feature state
   input  wire logic              ALIGN_PIN,
   input  wire logic              DEC_EN,
   input  wire logic              FEATURE_EN,
   // Converter samples in
   input  wire logic              ADC_VALID,
   input  wire rxc_sample_t       ADC_DATA,
   output      logic              ADC_READY,
   // Samples out to the host
   output      logic              OUT_VALID,
   output      rxc_sample_t       OUT_DATA,
   input  wire logic              OUT_READY,
   // Power and alignment status
   output      logic              CHAIN_OFF,
   output      logic              CHAN_A_OFF,
   output      logic              CHAN_B_OFF,
   output      logic              IQ_OFFSET_ALIGN,
   output      logic              IQ_GAINPHASE_ALIGN
);
   typedef struct packed {
      logic [7:0] mix_div;
      logic [7:0] pwr_byp;
      logic [7:0] align_off;
      logic [7:0] align_src;
      logic [7:0] strobe;
      logic [4:0] strobe_prev;
      logic       step_prev;
      logic       flip_prev;
      logic       pin_prev;
      logic [1:0] mix_phase;
      logic       div_phase;
      logic [7:0] rdata;
      logic       chain_off;
      logic       pd_a;
      logic       pd_b;
      logic       iq_ofs_evt;
      logic       iq_gp_evt;
   } rxc_state_t;

   rxc_state_t  st_reg;
   rxc_state_t  st_next;
   rxc_sample_t mixed;
   rxc_sample_t result;
   logic        fifo_ready;
   logic        take;
   logic        keep;
   logic        pin_rise;
   logic [4:0]  strobe_rise;
   logic        glob_evt;
   logic        mix_sync;
   logic        div_sync;
   logic        mix_on;
   logic        byp_on;
   logic        pd_a_now;
   logic        pd_b_now;

   // Sync event for one block given its disable and source bits
   function automatic logic blk_sync(input logic glob_off,
                                     input logic blk_off,
                                     input logic from_reg,
                                     input logic pin_edge,
                                     input logic strobe_edge,
                                     input logic glob_edge);
      if (glob_off) begin
         blk_sync = !blk_off && (from_reg ? strobe_edge : pin_edge);
      end else begin
         blk_sync = glob_edge;
      end
   endfunction

   function automatic logic [11:0] neg(input logic [11:0] x);
      neg = 12'(-x);
   endfunction

   // Complex rotation of (A + jB) by the mixer mode and phase
   function automatic rxc_sample_t mix(input rxc_sample_t s,
                                       input rxc_mix_mode_t m,
                                       input logic [1:0] ph);
      mix = s;
      unique case (m)
         RXC_MIX_PASS: mix = s;
         RXC_MIX_HALF: if (ph[0]) begin
            mix = '{a: neg(s.a), b: neg(s.b)};
         end
         RXC_MIX_QPOS: unique case (ph)
            2'h0: mix = s;
            2'h1: mix = '{a: neg(s.b), b: s.a};
            2'h2: mix = '{a: neg(s.a), b: neg(s.b)};
            2'h3: mix = '{a: s.b, b: neg(s.a)};
         endcase
         RXC_MIX_QNEG: unique case (ph)
            2'h0: mix = s;
            2'h1: mix = '{a: s.b, b: neg(s.a)};
            2'h2: mix = '{a: neg(s.a), b: neg(s.b)};
            2'h3: mix = '{a: neg(s.b), b: s.a};
         endcase
      endcase
   endfunction

   // Edge detection against last cycle's register and pin values
   always_comb begin
      pin_rise    = ALIGN_PIN && !st_reg.pin_prev;
      strobe_rise = st_reg.strobe[4:0] & ~st_reg.strobe_prev;
      glob_evt    = !st_reg.align_off[B_GLOBAL] &&
                    (st_reg.align_src[B_GLOBAL] ? strobe_rise[B_GLOBAL]
                                                : pin_rise);
      mix_sync = blk_sync(st_reg.align_off[B_GLOBAL],
                          st_reg.align_off[B_MIX], st_reg.align_src[B_MIX],
                          pin_rise, strobe_rise[B_MIX], glob_evt);
      div_sync = blk_sync(st_reg.align_off[B_GLOBAL],
                          st_reg.align_off[B_DIV], st_reg.align_src[B_DIV],
                          pin_rise, strobe_rise[B_DIV], glob_evt);
   end

   // Power-down and path selection from the power register
   always_comb begin
      mix_on = st_reg.mix_div[B_MIX_EN];
      byp_on = st_reg.pwr_byp[B_BYP] && st_reg.pwr_byp[B_BYP_APPLY];
      if (FEATURE_EN || mix_on) begin
         pd_a_now = st_reg.pwr_byp[B_A_PD] && st_reg.pwr_byp[B_A_APPLY];
         pd_b_now = st_reg.pwr_byp[B_B_PD] && st_reg.pwr_byp[B_B_APPLY];
      end else begin
         pd_a_now = &{st_reg.pwr_byp[B_A_PD], st_reg.pwr_byp[B_A_APPLY],
                      st_reg.pwr_byp[B_B_PD], st_reg.pwr_byp[B_B_APPLY]};
         pd_b_now = pd_a_now;
      end
   end

   // Sample path: mixer, decimation pick, mid-code substitution
   always_comb begin
      take = ADC_VALID && fifo_ready;
      if (mix_on) begin
         mixed = mix(ADC_DATA, rxc_mix_mode_t'(st_reg.mix_div[2:1]),
                     st_reg.mix_phase);
      end else begin
         mixed = ADC_DATA;
      end
      // Bypass skips mixer and divider; latency through the FIFO is the same as the mixed path
      if (byp_on) begin
         result = ADC_DATA;
         keep   = 1'b1;
      end else begin
         result = mixed;
         keep   = !DEC_EN || !st_reg.div_phase;
      end
      if (st_reg.chain_off || st_reg.pd_a) begin
         result.a = MID_CODE;
      end
      if (st_reg.chain_off || st_reg.pd_b) begin
         result.b = MID_CODE;
      end
   end

   // Register file, phase control and status
   always_comb begin
      st_next             = st_reg;
      st_next.strobe_prev = st_reg.strobe[4:0];
      st_next.step_prev   = st_reg.mix_div[B_MIX_STEP];
      st_next.flip_prev   = st_reg.mix_div[B_DIV_FLIP];
      st_next.pin_prev    = ALIGN_PIN;
      st_next.chain_off   = st_reg.pwr_byp[B_CHAIN_OFF];
      st_next.pd_a        = pd_a_now;
      st_next.pd_b        = pd_b_now;
      st_next.iq_ofs_evt  = blk_sync(st_reg.align_off[B_GLOBAL],
                                     st_reg.align_off[B_IQOFS],
                                     st_reg.align_src[B_IQOFS], pin_rise,
                                     strobe_rise[B_IQOFS], glob_evt);
      st_next.iq_gp_evt   = blk_sync(st_reg.align_off[B_GLOBAL],
                                     st_reg.align_off[B_IQGP],
                                     st_reg.align_src[B_IQGP], pin_rise,
                                     strobe_rise[B_IQGP], glob_evt);

      // Phases stop advancing with samples while the whole chain is powered down; step, flip and sync still act
      if (take && !st_reg.pwr_byp[B_CHAIN_OFF]) begin
         st_next.mix_phase = st_reg.mix_phase + 2'h1;
         st_next.div_phase = !st_reg.div_phase;
      end
      // Step only works with both global and mixer syncing off
      if (st_reg.mix_div[B_MIX_STEP] && !st_reg.step_prev &&
          st_reg.align_off[B_GLOBAL] && st_reg.align_off[B_MIX]) begin
         st_next.mix_phase = st_next.mix_phase + 2'h1;
      end
      if (st_reg.mix_div[B_DIV_FLIP] && !st_reg.flip_prev &&
          st_reg.align_off[B_GLOBAL] && st_reg.align_off[B_DIV]) begin
         st_next.div_phase = !st_next.div_phase;
      end
      // Sync wins over free running and stepping
      if (mix_sync) begin
         st_next.mix_phase = st_reg.mix_div[B_MIX_PRESET +: 2];
      end
      if (div_sync) begin
         st_next.div_phase = st_reg.mix_div[B_DIV_PRESET];
      end

      if (REG_WR) begin
         unique case (REG_ADDR)
            OFS_MIX_DIV:    st_next.mix_div   = REG_WDATA;
            OFS_PWR_BYP:    st_next.pwr_byp   = REG_WDATA;
            OFS_ALIGN_OFF:  st_next.align_off = REG_WDATA;
            OFS_ALIGN_SRC:  st_next.align_src = REG_WDATA;
            OFS_ALIGN_STRB: st_next.strobe    = REG_WDATA;
            default: ;
         endcase
      end

      // Read data stands for exactly the cycle after the strobe
      st_next.rdata = 8'h00;
      if (REG_RD) begin
         unique case (REG_ADDR)
            OFS_MIX_DIV:    st_next.rdata = st_reg.mix_div;
            OFS_PWR_BYP:    st_next.rdata = st_reg.pwr_byp;
            OFS_ALIGN_OFF:  st_next.rdata = st_reg.align_off;
            OFS_ALIGN_SRC:  st_next.rdata = st_reg.align_src;
            OFS_ALIGN_STRB: st_next.rdata = st_reg.strobe;
            OFS_STATUS: begin
               st_next.rdata[B_ST_PHASE +: 2] = st_reg.mix_phase;
               st_next.rdata[B_ST_DIV]        = st_reg.div_phase;
               st_next.rdata[B_ST_PDA]        = st_reg.pd_a;
               st_next.rdata[B_ST_PDB]        = st_reg.pd_b;
               st_next.rdata[B_ST_OFF]        = st_reg.chain_off;
            end
            default: st_next.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         st_reg           <= '0;
         st_reg.mix_div   <= RST_CFG;
         st_reg.pwr_byp   <= RST_CFG;
         st_reg.align_off <= RST_CFG;
         st_reg.align_src <= RST_CFG;
         st_reg.strobe    <= RST_CFG;
      end else begin
         st_reg <= st_next;
      end
   end

   // Decimated-away samples are consumed but never stored
   rxc_fifo #(
      .WIDTH ($bits(rxc_sample_t)),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (SYS_CLK),
      .rst       (RST),
      .in_valid  (take && keep),
      .in_data   (result),
      .in_ready  (fifo_ready),
      .out_valid (OUT_VALID),
      .out_data  (OUT_DATA),
      .out_ready (OUT_READY)
   );

   assign ADC_READY          = fifo_ready;
   assign REG_RDATA          = st_reg.rdata;
   assign CHAIN_OFF          = st_reg.chain_off;
   assign CHAN_A_OFF         = st_reg.pd_a;
   assign CHAN_B_OFF         = st_reg.pd_b;
   assign IQ_OFFSET_ALIGN    = st_reg.iq_ofs_evt;
   assign IQ_GAINPHASE_ALIGN = st_reg.iq_gp_evt;
endmodule // rxc_chain

// ---- dv/rxc_chain_asserts.sv ----
`timescale 1ns/10ps
// Port-level watch on register read timing, power copy and align pulses
module rxc_chain_chk
   import rxc_pkg::*;
(
   // Clock and reset
   input wire logic              SYS_CLK,
   input wire logic              RST,
   // Register port
   input wire logic [ADDR_W-1:0] REG_ADDR,
   input wire logic [DATA_W-1:0] REG_WDATA,
   input wire logic              REG_WR,
   input wire logic              REG_RD,
   input wire logic [DATA_W-1:0] REG_RDATA,
   // Stream, pin and status
   input wire logic              ALIGN_PIN,
   input wire logic              OUT_VALID,
   input wire rxc_sample_t       OUT_DATA,
   input wire logic              OUT_READY,
   input wire logic              CHAIN_OFF,
   input wire logic              IQ_OFFSET_ALIGN,
   input wire logic              IQ_GAINPHASE_ALIGN
);
   logic [7:0] off_reg;
   logic [7:0] src_reg;

   // Shadows of the align registers, so ports alone can judge the pulses
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         off_reg <= 8'h00;
         src_reg <= 8'h00;
      end else if (REG_WR && REG_ADDR == OFS_ALIGN_OFF) begin
         off_reg <= REG_WDATA;
      end else if (REG_WR && REG_ADDR == OFS_ALIGN_SRC) begin
         src_reg <= REG_WDATA;
      end
   end

   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   chk_rdata_idle: assert property (
      !$past(REG_RD) |-> REG_RDATA == 8'h00) else $error("rdata not idle");
   chk_read_shadow: assert property (
      REG_RD && REG_ADDR == OFS_ALIGN_OFF |=> REG_RDATA == off_reg)
      else $error("align disable readback wrong");
   chk_unmapped_read: assert property (
      REG_RD && REG_ADDR < 9'h166 |=> REG_RDATA == 8'h00)
      else $error("unmapped read not zero");
   chk_out_hold: assert property (
      OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA))
      else $error("output dropped while stalled");
   chk_chain_copy: assert property (
      REG_WR && REG_ADDR == OFS_PWR_BYP |-> ##2
      8'(CHAIN_OFF) == ($past(REG_WDATA, 2) & 8'h01))
      else $error("chain off flag wrong");
   chk_iq_single: assert property (
      IQ_OFFSET_ALIGN |=> !IQ_OFFSET_ALIGN) else $error("pulse too long");
   chk_glob_pin: assert property (
      !off_reg[4] && !src_reg[4] && $rose(ALIGN_PIN)
      |=> IQ_OFFSET_ALIGN && IQ_GAINPHASE_ALIGN)
      else $error("global pin sync missing");
   chk_glob_quiet: assert property (
      !off_reg[4] && !src_reg[4] && !$rose(ALIGN_PIN) |=> !IQ_OFFSET_ALIGN)
      else $error("sync without pin edge");
   chk_block_pin: assert property (
      off_reg[4] && !off_reg[2] && !src_reg[2] && $rose(ALIGN_PIN)
      |=> IQ_OFFSET_ALIGN) else $error("block pin sync missing");
   chk_block_mask: assert property (
      off_reg[4] && off_reg[3] |=> !IQ_GAINPHASE_ALIGN)
      else $error("disabled block synced");
endmodule // rxc_chain_chk

bind rxc_chain rxc_chain_chk chk (
   .SYS_CLK(SYS_CLK), .RST(RST), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .REG_RDATA(REG_RDATA), .ALIGN_PIN(ALIGN_PIN), .OUT_VALID(OUT_VALID),
   .OUT_DATA(OUT_DATA), .OUT_READY(OUT_READY), .CHAIN_OFF(CHAIN_OFF),
   .IQ_OFFSET_ALIGN(IQ_OFFSET_ALIGN), .IQ_GAINPHASE_ALIGN(IQ_GAINPHASE_ALIGN));

// ---- dv/rxc_host_model.sv ----
`timescale 1ns/10ps
// Host side sink; keeps every sample taken, in arrival order
module rxc_host_model
   import rxc_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Sample stream
   input wire logic        in_valid,
   input wire rxc_sample_t in_data,
   output     logic        in_ready,
   // Pacing from the bench
   input wire logic        stall,
   input wire logic        slow
);
   rxc_sample_t got_q[$];

   // Slow mode toggles ready, so the block sees stalls between takes
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         in_ready <= 1'b0;
      end else begin
         if (in_valid && in_ready) got_q.push_back(in_data);
         in_ready <= !stall && !(slow && in_ready);
      end
   end
endmodule // rxc_host_model

// ---- dv/rxc_chain_tb.sv ----
`timescale 1ns/10ps
module rxc_chain_tb
   import rxc_pkg::*;
;
   localparam int DEP = 4;
   logic              sys_clk, rst, reg_wr, reg_rd, align_pin, dec_en;
   logic              feature_en, adc_valid, adc_ready, out_valid, out_ready;
   logic              chain_off, chan_a_off, chan_b_off, iq_ofs, iq_gp;
   logic              stall, slow;
   logic [8:0]        reg_addr;
   logic [7:0]        reg_wdata, reg_rdata, d, d0;
   logic [31:0]       seed, r;
   rxc_sample_t       adc_data, out_data, s;
   int                n_errors, comparisons, i, n;
   logic [7:0]        pv[4] = '{8'h06, 8'h1e, 8'h06, 8'h18};
   logic [2:0]        pe[4] = '{3'b000, 3'b011, 3'b010, 3'b001};

   rxc_chain #(.DEPTH(DEP)) uut (.SYS_CLK(sys_clk), .RST(rst),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .ALIGN_PIN(align_pin),
      .DEC_EN(dec_en), .FEATURE_EN(feature_en), .ADC_VALID(adc_valid),
      .ADC_DATA(adc_data), .ADC_READY(adc_ready), .OUT_VALID(out_valid),
      .OUT_DATA(out_data), .OUT_READY(out_ready), .CHAIN_OFF(chain_off),
      .CHAN_A_OFF(chan_a_off), .CHAN_B_OFF(chan_b_off),
      .IQ_OFFSET_ALIGN(iq_ofs), .IQ_GAINPHASE_ALIGN(iq_gp));
   rxc_host_model host (.clk(sys_clk), .rst(rst), .in_valid(out_valid),
      .in_data(out_data), .in_ready(out_ready), .stall(stall), .slow(slow));

   // 25 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // Bench helpers: random source, expectations, bus and stream cycles
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic rxc_sample_t fs(int k);
      return '{12'(k * 3 + 1), 12'(k)};
   endfunction
   function automatic rxc_sample_t mixx(logic [1:0] m, logic [1:0] p,
                                        rxc_sample_t x);
      logic [1:0] k;
      k = (m == 2'h3) ? 2'h0 - p : p;  // Negative shift turns backwards
      if (m == 2'h1) k = {p[0], 1'b0};
      if (m == 2'h0) k = 2'h0;
      case (k)
         2'h0: return x;
         2'h1: return '{-x.b, x.a};
         2'h2: return '{-x.a, -x.b};
         default: return '{x.b, -x.a};
      endcase
   endfunction
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [8:0] a, input logic [7:0] v);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [8:0] a, output logic [7:0] v);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      v = reg_rdata;
   endtask
   // Pin high for one cycle; caller waits next, so no double drive
   task automatic pulse();
      align_pin <= 1'b1;
      @(posedge sys_clk);
      align_pin <= 1'b0;
   endtask
   task automatic seek(input bit gp, input logic exp);
      logic f;
      f = 1'b0;
      repeat (6) begin
         @(posedge sys_clk);
         if ((gp ? iq_gp : iq_ofs) === 1'b1) f = 1'b1;
      end
      chk(f, exp);
   endtask
   // Valid stays up after the take; caller lowers it
   task automatic send(input rxc_sample_t x);
      int k;
      adc_valid <= 1'b1;
      adc_data <= x;
      for (k = 0; k < 40; k++) begin
         @(posedge sys_clk);
         if (adc_ready === 1'b1) break;
      end
      if (k == 40) begin
         n_errors++;
         results();
      end
   endtask
   task automatic take(input rxc_sample_t e);
      int k;
      for (k = 0; k < 40 && host.got_q.size() == 0; k++) @(posedge sys_clk);
      if (k == 40) begin
         n_errors++;
         results();
      end
      chk(host.got_q.pop_front(), e);
   endtask

   // Main sequence
   initial begin
      {rst, reg_wr, reg_rd, align_pin, dec_en, feature_en} = 6'b100000;
      {adc_valid, stall, slow} = 3'b000;
      reg_addr = 9'h000;
      reg_wdata = 8'h00;
      adc_data = '0;
      seed = 32'd81;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      for (i = 0; i < 4; i++) begin
         rd(OFS_MIX_DIV + 9'(i), d);
         chk(d, RST_CFG);
         r = rnd();
         wr(OFS_MIX_DIV + 9'(i), r[7:0]);
         rd(OFS_MIX_DIV + 9'(i), d);
         chk(d, r[7:0]);
         wr(OFS_MIX_DIV + 9'(i), 8'h00);
      end
      rd(9'h100, d);
      chk(d, 8'h00);
      pulse();
      seek(0, 1);
      wr(OFS_ALIGN_SRC, 8'h10);
      pulse();
      seek(0, 0);
      wr(OFS_ALIGN_STRB, 8'h10);
      seek(1, 1);
      wr(OFS_ALIGN_STRB, 8'h00);
      wr(OFS_ALIGN_SRC, 8'h00);
      wr(OFS_ALIGN_OFF, 8'h0c);
      pulse();
      seek(1, 1);
      wr(OFS_ALIGN_OFF, 8'h18);
      wr(OFS_ALIGN_SRC, 8'h04);
      pulse();
      seek(0, 0);
      wr(OFS_ALIGN_STRB, 8'h04);
      seek(0, 1);
      wr(OFS_ALIGN_STRB, 8'h00);
      // Block back on the pin: pin edge alone syncs the offset block
      wr(OFS_ALIGN_SRC, 8'h00);
      pulse();
      seek(0, 1);
      // Mixer step only with both sync levels off
      wr(OFS_ALIGN_OFF, 8'h11);
      rd(OFS_STATUS, d0);
      wr(OFS_MIX_DIV, 8'h08);
      wr(OFS_MIX_DIV, 8'h08);
      wr(OFS_MIX_DIV, 8'h00);
      wr(OFS_MIX_DIV, 8'h08);
      rd(OFS_STATUS, d);
      chk(d[1:0], 2'(d0[1:0] + 2'h2));
      wr(OFS_ALIGN_OFF, 8'h10);
      wr(OFS_MIX_DIV, 8'h00);
      wr(OFS_MIX_DIV, 8'h08);
      rd(OFS_STATUS, d0);
      chk(d0[1:0], d[1:0]);
      wr(OFS_ALIGN_OFF, 8'h12);
      wr(OFS_MIX_DIV, 8'h80);
      rd(OFS_STATUS, d);
      chk(d[2], !d0[2]);
      wr(OFS_ALIGN_OFF, 8'h10);
      wr(OFS_MIX_DIV, 8'h00);
      wr(OFS_MIX_DIV, 8'h80);
      rd(OFS_STATUS, d0);
      chk(d0[2], d[2]);
      wr(OFS_ALIGN_OFF, 8'h00);
      wr(OFS_MIX_DIV, 8'h70);
      pulse();
      rd(OFS_STATUS, d);
      chk(d[2:0], 3'h7);
      // Every mode, enabled and not, against a slow host
      slow <= 1'b1;
      for (i = 0; i < 8; i++) begin
         r = rnd();
         s = r[23:0];
         wr(OFS_MIX_DIV, {2'b00, r[25:24], 1'b0, i[2:1], i[0]});
         pulse();
         send(s);
         adc_valid <= 1'b0;
         take(i[0] ? mixx(i[2:1], r[25:24], s) : s);
      end
      slow <= 1'b0;
      wr(OFS_MIX_DIV, 8'h33);
      pulse();
      wr(OFS_PWR_BYP, 8'h60);
      send(s);
      adc_valid <= 1'b0;
      take(s);
      wr(OFS_PWR_BYP, 8'h00);
      wr(OFS_MIX_DIV, 8'h00);
      pulse();
      dec_en <= 1'b1;
      for (i = 0; i < 4; i++) send(fs(i));
      adc_valid <= 1'b0;
      take(fs(0));
      take(fs(2));
      dec_en <= 1'b0;
      // Power-down table; mixer off, so the feature flag decides
      for (i = 0; i < 4; i++) begin
         feature_en <= i[1];
         wr(OFS_PWR_BYP, pv[i]);
         repeat (2) @(posedge sys_clk);
         chk({chain_off, chan_a_off, chan_b_off}, pe[i]);
         send(fs(i));
         adc_valid <= 1'b0;
         s = fs(i);
         take('{pe[i][1] ? MID_CODE : s.a, pe[i][0] ? MID_CODE : s.b});
      end
      wr(OFS_PWR_BYP, 8'h01);
      rd(OFS_STATUS, d);
      chk(d[5], 1'b1);
      send(fs(7));
      adc_valid <= 1'b0;
      take('{MID_CODE, MID_CODE});
      wr(OFS_PWR_BYP, 8'h00);
      // Fill until refused with the host stalled, then drain in order
      stall <= 1'b1;
      adc_valid <= 1'b1;
      adc_data <= fs(0);
      n = 0;
      for (i = 0; i < 12; i++) begin
         @(posedge sys_clk);
         if (adc_ready === 1'b1) begin
            n++;
            adc_data <= fs(n);
         end
      end
      adc_valid <= 1'b0;
      chk(n, DEP + 1);
      stall <= 1'b0;
      for (i = 0; i < n; i++) take(fs(i));
      results();
   end
endmodule // rxc_chain_tb
